/* File: design/tepcu_pkg.sv */
// constants and types for the timer, event counter, square-wave and capture unit
`default_nettype none

package tepcu_pkg;

  localparam int COUNT_W = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] QUAD_INIT = 16'h7fff;

  // default prescaler division ratio, in mclk cycles per tick
  localparam int PRESCALE_DIV = 2;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [7:0] PRE_ONE = 8'h01;

  // count source select
  localparam logic CLK_SEL_EXT = 1'b0;
  localparam logic CLK_SEL_PRE = 1'b1;

  // capture trigger modes
  typedef enum logic [1:0] {
    TEPCU_CAP_OFF = 2'b00,
    TEPCU_CAP_PINS_RISE = 2'b01,
    TEPCU_CAP_A_BOTH = 2'b10,
    TEPCU_CAP_GATE = 2'b11
  } tepcu_cap_mode_t;

  // invert-enable field values
  localparam logic [1:0] INV_NONE = 2'b00;
  localparam logic [1:0] INV_BOTH = 2'b11;
  localparam int INV_LO_BIT = 0;
  localparam int INV_HI_BIT = 1;

  // status flag positions
  localparam int ST_MATCH_LO = 0;
  localparam int ST_MATCH_HI = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_UNDERFLOW = 3;
  localparam int ST_STEP = 4;
  localparam int ST_W = 5;

endpackage

`default_nettype wire

/* File: design/tepcu_timer.sv */
// timer unit: event counter, square-wave output, capture and quadrature counting
`default_nettype none

module tepcu_timer #(
  parameter int PRESCALE_DIV = tepcu_pkg::PRESCALE_DIV,
  parameter bit QUAD_CAPABLE = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // control bits
  input wire logic count_run_bit,
  input wire logic prescaler_run_bit,
  input wire logic clock_select,
  input wire logic square_wave_mode,
  input wire logic double_buffer_enable,
  input wire logic [1:0] invert_enable,
  input wire logic invert_on_capture,
  input wire logic [1:0] capture_mode_field,
  input wire logic updown_enable,
  // output flop initialise strobe and value
  input wire logic flop_load,
  input wire logic flop_load_value,
  // compare register writes
  input wire logic compare_lo_write,
  input wire logic compare_hi_write,
  input wire logic [15:0] compare_data,
  // software capture strobe and status clear strobe
  input wire logic soft_capture,
  input wire logic status_clear,
  // external pins
  input wire logic ext_input_a,
  input wire logic ext_input_b,
  input wire logic gate_timer_flop,
  input wire logic quad_phase_a,
  input wire logic quad_phase_b,
  // results
  output logic wave_output_pin,
  output logic [15:0] capture_reg_a,
  output logic [15:0] capture_reg_b,
  output logic [15:0] compare_reg_lo,
  output logic [15:0] compare_reg_hi,
  output logic [tepcu_pkg::ST_W-1:0] status_flags,
  output logic timer_match_irq
);

  localparam logic [7:0] PRE_LAST = 8'(PRESCALE_DIV - 1);

  logic [15:0] up_counter_reg;
  logic [15:0] up_counter_next;
  logic [15:0] duty_buffer_reg;
  logic [7:0] pre_count_reg;
  logic pre_tick_reg;
  logic ext_a_reg;
  logic ext_b_reg;
  logic gate_reg;
  logic phase_a_reg;
  logic phase_b_reg;
  logic updown_reg;
  logic quad_active;
  logic count_tick;
  logic match_lo;
  logic match_hi;
  logic overflow;
  logic quad_step;
  logic quad_up;
  logic quad_down;
  logic underflow;
  logic cap_a_event;
  logic cap_b_event;
  logic flop_toggle;
  logic [tepcu_pkg::ST_W-1:0] status_set;

  // ------------------------------------------------------------
  // input edge history
  // ------------------------------------------------------------

  // pins are synchronous, so one stage of history is enough for edges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_a_reg <= 1'b0;
      ext_b_reg <= 1'b0;
      gate_reg <= 1'b0;
      phase_a_reg <= 1'b0;
      phase_b_reg <= 1'b0;
      updown_reg <= 1'b0;
    end else begin
      ext_a_reg <= ext_input_a;
      ext_b_reg <= ext_input_b;
      gate_reg <= gate_timer_flop;
      phase_a_reg <= quad_phase_a;
      phase_b_reg <= quad_phase_b;
      updown_reg <= updown_enable;
    end
  end

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------

  // free-running divider; it is held at zero, with no tick, while the run bit is low
  always_ff @(posedge mclk) begin
    if (sys_rst || !prescaler_run_bit) begin
      pre_count_reg <= tepcu_pkg::PRE_ZERO;
      pre_tick_reg <= 1'b0;
    end else if (pre_count_reg >= PRE_LAST) begin
      pre_count_reg <= tepcu_pkg::PRE_ZERO;
      pre_tick_reg <= 1'b1;
    end else begin
      pre_count_reg <= pre_count_reg + tepcu_pkg::PRE_ONE;
      pre_tick_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // count source, matches and quadrature decode
  // ------------------------------------------------------------

  // quadrature only exists where the instance was built with it
  assign quad_active = QUAD_CAPABLE && updown_enable;

  // external source steps on rising edges of ext_input_a
  assign count_tick = count_run_bit && !quad_active &&
    ((clock_select == tepcu_pkg::CLK_SEL_EXT) ? (ext_input_a && !ext_a_reg) : pre_tick_reg);

  // comparator is idle in quadrature mode
  assign match_lo = count_tick && (up_counter_reg == compare_reg_lo);
  assign match_hi = count_tick && (up_counter_reg == compare_reg_hi);
  assign overflow = count_tick && (up_counter_reg == tepcu_pkg::CNT_MAX) &&
    !(square_wave_mode && match_hi);

  // a leads b counts up; both changing at once is an illegal pair and is ignored
  assign quad_up = (quad_phase_a ^ phase_a_reg) ? (quad_phase_a != quad_phase_b)
                                                : (quad_phase_a == quad_phase_b);
  assign quad_step = quad_active && count_run_bit && updown_reg &&
    ((quad_phase_a ^ phase_a_reg) ^ (quad_phase_b ^ phase_b_reg));
  assign quad_down = quad_step && !quad_up;
  assign underflow = quad_down && (up_counter_reg == tepcu_pkg::CNT_ZERO);

  // next counter value; the quadrature wrap gives the reload values for free
  always_comb begin
    up_counter_next = up_counter_reg;
    if (!count_run_bit) begin
      up_counter_next = tepcu_pkg::CNT_ZERO;
    end else if (quad_active && !updown_reg) begin
      up_counter_next = tepcu_pkg::QUAD_INIT;
    end else if (quad_step) begin
      up_counter_next = quad_up ? up_counter_reg + tepcu_pkg::CNT_ONE
                                : up_counter_reg - tepcu_pkg::CNT_ONE;
    end else if (square_wave_mode && match_hi) begin
      up_counter_next = tepcu_pkg::CNT_ZERO;
    end else if (count_tick) begin
      up_counter_next = up_counter_reg + tepcu_pkg::CNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // up-counter
  // ------------------------------------------------------------

  // the count has no output port; software sees it only through a capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      up_counter_reg <= tepcu_pkg::CNT_ZERO;
    end else begin
      up_counter_reg <= up_counter_next;
    end
  end

  // ------------------------------------------------------------
  // compare registers with duty double buffer
  // ------------------------------------------------------------

  // buffering lets the duty change land at a period boundary, avoiding glitches
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      compare_reg_lo <= tepcu_pkg::CNT_ZERO;
      compare_reg_hi <= tepcu_pkg::CNT_ZERO;
      duty_buffer_reg <= tepcu_pkg::CNT_ZERO;
    end else begin
      if (compare_lo_write) begin
        duty_buffer_reg <= compare_data;
      end
      if (compare_lo_write && !double_buffer_enable) begin
        compare_reg_lo <= compare_data;
      end else if (double_buffer_enable && match_hi) begin
        compare_reg_lo <= duty_buffer_reg;
      end
      if (compare_hi_write) begin
        compare_reg_hi <= compare_data;
      end
    end
  end

  // ------------------------------------------------------------
  // capture triggers and capture registers
  // ------------------------------------------------------------

  // capture register a takes the rising-type trigger of every mode
  always_comb begin
    cap_a_event = 1'b0;
    cap_b_event = 1'b0;
    case (tepcu_pkg::tepcu_cap_mode_t'(capture_mode_field))
      tepcu_pkg::TEPCU_CAP_OFF: begin
        cap_a_event = 1'b0;
      end
      tepcu_pkg::TEPCU_CAP_PINS_RISE: begin
        cap_a_event = ext_input_a && !ext_a_reg;
        cap_b_event = ext_input_b && !ext_b_reg;
      end
      tepcu_pkg::TEPCU_CAP_A_BOTH: begin
        cap_a_event = ext_input_a && !ext_a_reg;
        cap_b_event = !ext_input_a && ext_a_reg;
      end
      tepcu_pkg::TEPCU_CAP_GATE: begin
        cap_a_event = gate_timer_flop && !gate_reg;
        cap_b_event = !gate_timer_flop && gate_reg;
      end
      default: begin
        cap_a_event = 1'b0;
      end
    endcase
    // pin captures are off in quadrature mode; only software capture stays
    if (quad_active) begin
      cap_a_event = 1'b0;
      cap_b_event = 1'b0;
    end
  end

  // software and pin captures are the only window onto the running count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      capture_reg_a <= tepcu_pkg::CNT_ZERO;
      capture_reg_b <= tepcu_pkg::CNT_ZERO;
    end else begin
      if (soft_capture || cap_a_event) begin
        capture_reg_a <= up_counter_reg;
      end
      if (cap_b_event) begin
        capture_reg_b <= up_counter_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // output flop
  // ------------------------------------------------------------

  // each enabled source toggles; two sources in one cycle cancel out
  assign flop_toggle = (invert_enable[tepcu_pkg::INV_LO_BIT] && match_lo) ^
                       (invert_enable[tepcu_pkg::INV_HI_BIT] && match_hi) ^
                       (invert_on_capture && cap_a_event);

  // initial value picks low- or high-active pulses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wave_output_pin <= 1'b0;
    end else if (flop_load) begin
      wave_output_pin <= flop_load_value;
    end else if (flop_toggle) begin
      wave_output_pin <= !wave_output_pin;
    end
  end

  // ------------------------------------------------------------
  // status flags and interrupt
  // ------------------------------------------------------------

  always_comb begin
    status_set = '0;
    status_set[tepcu_pkg::ST_MATCH_LO] = match_lo;
    status_set[tepcu_pkg::ST_MATCH_HI] = match_hi;
    status_set[tepcu_pkg::ST_OVERFLOW] = overflow || (quad_step && quad_up &&
                                         up_counter_reg == tepcu_pkg::CNT_MAX);
    status_set[tepcu_pkg::ST_UNDERFLOW] = underflow;
    status_set[tepcu_pkg::ST_STEP] = quad_step;
  end

  // sticky flags; a new event in the clearing cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_flags <= '0;
    end else begin
      status_flags <= (status_clear ? '0 : status_flags) | status_set;
    end
  end

  // one-cycle interrupt pulse per cycle with any event; events in one cycle share it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_match_irq <= 1'b0;
    end else begin
      timer_match_irq <= |status_set;
    end
  end

endmodule

`default_nettype wire

/* File: sim/tb_timer_event_ppg_capture_unit.sv */
// self-checking bench for the timer unit
`default_nettype none
module tb_timer_event_ppg_capture_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PDIV = 2;
  logic mclk, sys_rst, run, pre, csel, sqw, dbe, ioc, ude, fl, flv, low, hiw, scap, sclr;
  logic [1:0] inv, cmode;
  logic [15:0] cdata, cap_a, cap_b, clo, chi;
  logic [4:0] st;
  logic wave, irq, pa, pb, gt, qa, qb, w, irq_seen;
  int n_fail, total_checks, cyc;
  tepcu_timer #(.PRESCALE_DIV(PDIV), .QUAD_CAPABLE(1'b1)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .count_run_bit(run), .prescaler_run_bit(pre), .clock_select(csel), .square_wave_mode(sqw),
    .double_buffer_enable(dbe), .invert_enable(inv), .invert_on_capture(ioc), .capture_mode_field(cmode),
    .updown_enable(ude), .flop_load(fl), .flop_load_value(flv), .compare_lo_write(low),
    .compare_hi_write(hiw), .compare_data(cdata), .soft_capture(scap), .status_clear(sclr),
    .ext_input_a(pa), .ext_input_b(pb), .gate_timer_flop(gt), .quad_phase_a(qa), .quad_phase_b(qb),
    .wave_output_pin(wave), .capture_reg_a(cap_a), .capture_reg_b(cap_b), .compare_reg_lo(clo),
    .compare_reg_hi(chi), .status_flags(st), .timer_match_irq(irq));
  tepcu_pin_src src (.mclk(mclk), .ext_a(pa), .ext_b(pb), .gate(gt), .ph_a(qa), .ph_b(qb));
  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard, well above the long quadrature walk
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_seen <= 1'b1;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // strobes stay up one full cycle
  task automatic cap();
    @(negedge mclk) scap = !scap;
    @(negedge mclk) scap = !scap;
  endtask
  task automatic wr(input bit hi, input logic [15:0] d);
    @(negedge mclk) cdata = d;
    hiw = hi;
    low = !hi;
    @(negedge mclk) hiw = 1'b0;
    low = 1'b0;
  endtask
  // level controls in one call: prescaler run, source, square wave, buffer, capture invert, invert field
  task automatic ctl(input logic p, input logic c, input logic s, input logic d, input logic o,
    input logic [1:0] i);
    pre = p;
    csel = c;
    sqw = s;
    dbe = d;
    ioc = o;
    inv = i;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_event();
    ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b0, 1'b0, 1'b0, tepcu_pkg::INV_NONE);
    run = 1'b1;
    src.pulse_a(5);
    chk("pin capture off", cap_a, 16'h0000);
    cap();
    chk("event count", cap_a, 16'h0005);
    @(negedge mclk) run = 1'b0;
    cap();
    chk("capture while stopped", cap_a, 16'h0000);
    @(negedge mclk) run = 1'b1;
    src.pulse_a(2);
    cap();
    chk("count after stop", cap_a, 16'h0002);
  endtask
  // event pins as count clock keep every match on a known pulse
  task automatic t_wave();
    for (int i = 0; i < 2; i++) begin
      // safe reconfigure: stop, invert off, start, stop, change, start
      @(negedge mclk) run = 1'b0;
      ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b1, 1'b0, 1'b0, tepcu_pkg::INV_NONE);
      @(negedge mclk) run = 1'b1;
      @(negedge mclk) run = 1'b0;
      ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b1, 1'b0, 1'b0, tepcu_pkg::INV_BOTH);
      wr(1'b1, 16'h0004);
      chk("hi compare", chi, 16'h0004);
      wr(1'b0, 16'h0002);
      @(negedge mclk) fl = 1'b1;
      flv = i[0];
      @(negedge mclk) fl = 1'b0;
      run = 1'b1;
      src.pulse_a(3);
      chk("duty edge", wave, !i[0]);
      src.pulse_a(2);
      chk("period edge", wave, i[0]);
      cap();
      chk("period clear", cap_a, 16'h0000);
    end
    chk("match flags", st[1:0], 2'b11);
    chk("match irq", irq_seen, 1'b1);
    ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b1, 1'b1, 1'b0, tepcu_pkg::INV_BOTH);
    wr(1'b0, 16'h0001);
    chk("lo held", clo, 16'h0002);
    src.pulse_a(5);
    chk("lo moved", clo, 16'h0001);
    w = wave;
    ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b1, 1'b1, 1'b0, tepcu_pkg::INV_NONE);
    src.pulse_a(5);
    chk("no invert", wave, w);
    ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b1, 1'b1, 1'b0, 2'b10);
    src.pulse_a(5);
    chk("hi invert only", wave, !w);
    ctl(1'b1, tepcu_pkg::CLK_SEL_EXT, 1'b0, 1'b0, 1'b0, 2'b10);
  endtask
  // span between two captures is gap mclk cycles, so gap / PDIV prescaler ticks
  task automatic pair(input logic [1:0] m, input logic [2:0] on, input logic [2:0] off, input int gap);
    cmode = m;
    src.lvl(on);
    repeat (gap - 1) @(negedge mclk);
    src.lvl(off);
    src.lvl(3'b000);
    @(negedge mclk);
    chk("capture span", cap_b - cap_a, 16'(gap / PDIV));
  endtask
  task automatic t_capture();
    logic [15:0] old;
    ctl(1'b1, tepcu_pkg::CLK_SEL_PRE, 1'b0, 1'b0, 1'b0, tepcu_pkg::INV_NONE);
    pair(2'b01, 3'b100, 3'b110, 8);
    pair(2'b10, 3'b100, 3'b000, 20);
    pair(2'b11, 3'b001, 3'b000, 12);
    w = wave;
    ctl(1'b1, tepcu_pkg::CLK_SEL_PRE, 1'b0, 1'b0, 1'b1, tepcu_pkg::INV_NONE);
    cmode = 2'b10;
    old = cap_a;
    src.lvl(3'b100);
    @(negedge mclk);
    chk("pin capture", cap_a != old, 1'b1);
    chk("capture invert", wave, !w);
    ctl(1'b1, tepcu_pkg::CLK_SEL_PRE, 1'b0, 1'b0, 1'b0, tepcu_pkg::INV_NONE);
    cmode = 2'b00;
    src.lvl(3'b000);
    old = cap_a;
    src.lvl(3'b100);
    src.lvl(3'b000);
    @(negedge mclk);
    chk("capture off", cap_a, old);
  endtask
  task automatic t_quad();
    @(negedge mclk) run = 1'b0;
    @(negedge mclk) sclr = 1'b1;
    @(negedge mclk) sclr = 1'b0;
    run = 1'b1;
    ude = 1'b1;
    src.quad(1'b1, 3);
    cap();
    chk("quad up", cap_a, 16'h8002);
    src.quad(1'b0, 2);
    cap();
    chk("quad down", cap_a, 16'h8000);
    chk("step flag", st, 5'h10);
    src.quad(1'b1, 32768);
    cap();
    chk("wrap to zero", cap_a, 16'h0000);
    chk("overflow flag", st[2], 1'b1);
    src.quad(1'b0, 1);
    cap();
    chk("wrap to max", cap_a, 16'hffff);
    chk("underflow flag", st[3], 1'b1);
    @(negedge mclk) ude = 1'b0;
    @(negedge mclk) ude = 1'b1;
    cap();
    chk("quad reload", cap_a, 16'h7fff);
  endtask
  // main sequence
  initial begin
    {run, pre, csel, sqw, dbe, ioc, ude, fl, flv, low, hiw, scap, sclr, irq_seen, inv, cmode, cdata} = '0;
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    t_event();
    t_wave();
    t_capture();
    t_quad();
    finish_test();
  end
endmodule
`default_nettype wire

/* File: sim/tepcu_pin_src.sv */
// pin source model: count pulses, capture levels, quadrature phases
`default_nettype none
module tepcu_pin_src (
  input wire logic mclk,
  output logic ext_a,
  output logic ext_b,
  output logic gate,
  output logic ph_a,
  output logic ph_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] qs;
  // pins idle low, phases at 00
  initial begin
    {ext_a, ext_b, gate, ph_a, ph_b, qs} = 7'h00;
  end
  // levels on {a, b, gate}, changed off the sampling edge
  task automatic lvl(input logic [2:0] v);
    @(negedge mclk) {ext_a, ext_b, gate} = v;
  endtask
  // one cycle high, one low, so every rise is sampled
  task automatic pulse_a(input int n);
    repeat (n) begin
      @(negedge mclk) ext_a = 1'b1;
      @(negedge mclk) ext_a = 1'b0;
    end
  endtask
  // gray walk 00-10-11-01: one phase moves per cycle
  task automatic quad(input bit up, input int n);
    repeat (n) begin
      @(negedge mclk) qs = up ? qs + 2'h1 : qs - 2'h1;
      ph_a = qs[1] ^ qs[0];
      ph_b = qs[1];
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/tepcu_timer_asserts.sv */
// port-level assertions for the timer unit
`default_nettype none
module tepcu_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic count_run_bit,
  input wire logic soft_capture,
  input wire logic [15:0] capture_reg_a,
  input wire logic [tepcu_pkg::ST_W-1:0] status_flags,
  input wire logic status_clear,
  input wire logic timer_match_irq,
  input wire logic wave_output_pin,
  input wire logic flop_load,
  input wire logic flop_load_value,
  input wire logic [1:0] invert_enable,
  input wire logic invert_on_capture,
  input wire logic compare_hi_write,
  input wire logic [15:0] compare_data,
  input wire logic [15:0] compare_reg_hi,
  input wire logic [15:0] compare_reg_lo,
  input wire logic double_buffer_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // checks, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_RUN_CLEAR: assert property (!$past(count_run_bit) && !count_run_bit && soft_capture
    |=> capture_reg_a == 16'h0000) else $error("capture not zero while stopped");
  // flag and pulse leave on the same edge, so they are seen in the same cycle
  AST_IRQ_AFTER: assert property ((status_flags & ~$past(status_flags)) != 5'h00 |-> timer_match_irq)
    else $error("no irq with new flag");
  AST_IRQ_CAUSE: assert property (timer_match_irq |-> status_flags != 5'h00)
    else $error("irq without flag");
  AST_STICKY: assert property (status_flags[0] && !status_clear |=> status_flags[0])
    else $error("match flag lost");
  AST_WAVE_CAUSE: assert property ($changed(wave_output_pin) |-> $past(flop_load)
    || $past(invert_enable) != 2'b00 || $past(invert_on_capture)) else $error("wave moved without cause");
  AST_FLOP_LOAD: assert property (flop_load |=> wave_output_pin == $past(flop_load_value))
    else $error("flop load ignored");
  AST_HI_WRITE: assert property (compare_hi_write |=> compare_reg_hi == $past(compare_data))
    else $error("hi compare write lost");
  AST_LO_BUFFERED: assert property ($changed(compare_reg_lo) && $past(double_buffer_enable)
    |-> status_flags[1]) else $error("lo moved outside hi match");
  AST_UNDER_STEP: assert property ($rose(status_flags[3]) |-> status_flags[4])
    else $error("underflow without step flag");
endmodule
bind tepcu_timer tepcu_asserts chk (.mclk(mclk), .sys_rst(sys_rst), .count_run_bit(count_run_bit),
  .soft_capture(soft_capture), .capture_reg_a(capture_reg_a), .status_flags(status_flags),
  .status_clear(status_clear), .timer_match_irq(timer_match_irq), .wave_output_pin(wave_output_pin),
  .flop_load(flop_load), .flop_load_value(flop_load_value), .invert_enable(invert_enable),
  .invert_on_capture(invert_on_capture), .compare_hi_write(compare_hi_write), .compare_data(compare_data),
  .compare_reg_hi(compare_reg_hi), .compare_reg_lo(compare_reg_lo), .double_buffer_enable(double_buffer_enable));
`default_nettype wire
